// File: logic/fepc_ctrl.sv
module fepc_ctrl
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Special function register port from the processor core.
    input wire fepc_pkg::fepc_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    // Processor state.
    input wire logic irq_global_enabled,
    input wire logic movx_dptr_store,
    input wire logic [15:0] dptr,
    input wire logic [7:0] acc,
    // Debug port enable, an asynchronous pin level.
    input wire logic debug_port_enabled,
    // Flash array side.
    input wire logic flash_busy,
    output fepc_pkg::fepc_erase_s erase_cmd,
    output fepc_pkg::fepc_byte_s flash_write,
    // Store steering and security.
    output logic xram_store,
    output logic readout_block
);
    import fepc_pkg::*;

    logic pwe;
    logic arm;
    logic secure;
    logic [7:0] page_select;
    logic debug_ok;

    fepc_sync u_dbg_sync
    (
        .clk(clk),
        .reset(reset),
        .din(debug_port_enabled),
        .dout(debug_ok)
    );

    wire wr_erase = sfr.we && sfr.addr == FEPC_ADDR_ERASE;
    wire wr_ctrl = sfr.we && sfr.addr == FEPC_ADDR_CTRL;
    wire wr_page = sfr.we && sfr.addr == FEPC_ADDR_PAGE;
    wire pat_mass = wr_erase && sfr.wdata == FEPC_PAT_MASS;
    wire pat_page = wr_erase && sfr.wdata == FEPC_PAT_PAGE;
    // Patterns other than the two are simply not decoded.
    wire go_mass = pat_mass && arm && debug_ok && !flash_busy;
    wire go_page = pat_page && !flash_busy;
    // A store while the enable is set lands in flash at the pointer address.
    wire flash_store = movx_dptr_store && pwe;
    wire pwe_write_ok = wr_ctrl && !irq_global_enabled;
    wire [7:0] ctrl_view = {1'b0, secure, 4'h0, arm, pwe};
    wire [7:0] next_rdata = (sfr.addr == FEPC_ADDR_CTRL) ? ctrl_view
        : (sfr.addr == FEPC_ADDR_PAGE) ? page_select : 8'h00;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pwe <= 1'b0;
        end
        else if (flash_store)
        begin
            pwe <= 1'b0;
        end
        else if (pwe_write_ok)
        begin
            pwe <= sfr.wdata[FEPC_BIT_PWE];
        end
    end

    // One arming is consumed by any mass trigger, successful or not.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            arm <= 1'b0;
        end
        else if (pat_mass)
        begin
            arm <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            arm <= sfr.wdata[FEPC_BIT_ARM];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            secure <= 1'b0;
        end
        else if (wr_ctrl && sfr.wdata[FEPC_BIT_SECURE])
        begin
            secure <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            page_select <= FEPC_PAGE_RESET;
        end
        else if (wr_page)
        begin
            page_select <= sfr.wdata;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            erase_cmd <= '0;
            flash_write <= '0;
            xram_store <= 1'b0;
            readout_block <= 1'b0;
            sfr_rdata <= 8'h00;
        end
        else
        begin
            erase_cmd.req <= go_mass || go_page;
            erase_cmd.mass <= go_mass;
            // Bit 0 is dropped; the seven upper bits name one of the 128 pages.
            erase_cmd.page <= page_select[7:1];
            flash_write.we <= flash_store;
            flash_write.addr <= dptr;
            flash_write.data <= acc;
            xram_store <= movx_dptr_store && !pwe;
            readout_block <= secure;
            sfr_rdata <= sfr.re ? next_rdata : 8'h00;
        end
    end
endmodule : fepc_ctrl

// File: logic/fepc_pkg.sv
package fepc_pkg;
    localparam logic [7:0] FEPC_ADDR_ERASE = 8'h94;
    localparam logic [7:0] FEPC_ADDR_CTRL = 8'hb2;
    localparam logic [7:0] FEPC_ADDR_PAGE = 8'hb7;
    localparam logic [7:0] FEPC_PAT_MASS = 8'haa;
    localparam logic [7:0] FEPC_PAT_PAGE = 8'h55;
    localparam int FEPC_BIT_PWE = 0;
    localparam int FEPC_BIT_ARM = 1;
    localparam int FEPC_BIT_SECURE = 6;
    localparam logic [7:0] FEPC_PAGE_RESET = 8'h00;
    localparam int FEPC_PAGES = 128;
    localparam int FEPC_PAGE_BYTES = 512;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fepc_sfr_s;

    typedef struct packed {
        logic req;
        logic mass;
        logic [6:0] page;
    } fepc_erase_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } fepc_byte_s;
endpackage : fepc_pkg

// File: logic/fepc_sync.sv
module fepc_sync
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Asynchronous level in, filtered level out.
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    // The output only moves once the second and third stages agree.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                dout <= s3;
            end
        end
    end
endmodule : fepc_sync

// File: tb/fepc_ctrl_assertions.sv
module fepc_ctrl_assertions
(
    // Watched ports.
    input wire logic clk,
    input wire logic reset,
    input wire fepc_pkg::fepc_sfr_s sfr,
    input wire logic movx_dptr_store,
    input wire logic debug_port_enabled,
    input wire logic flash_busy,
    input wire fepc_pkg::fepc_erase_s erase_cmd,
    input wire fepc_pkg::fepc_byte_s flash_write,
    input wire logic xram_store,
    input wire logic readout_block
);
    timeunit 1ns / 1ps;
    import fepc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire t = sfr.we && sfr.addr == FEPC_ADDR_ERASE && !flash_busy;
    wire mass_try = t && sfr.wdata == FEPC_PAT_MASS;
    chk_page_start: assert property (t && sfr.wdata == 8'h55 |=> erase_cmd.req && !erase_cmd.mass)
        else $error("page");
    chk_odd_pattern: assert property (t && sfr.wdata != 8'h55 && sfr.wdata != 8'haa |=> !erase_cmd.req)
        else $error("odd");
    chk_mass_cause: assert property (erase_cmd.req && erase_cmd.mass |-> $past(mass_try))
        else $error("mass");
    chk_debug_gate: assert property ((!debug_port_enabled) [*6] ##0 mass_try |=> !erase_cmd.req)
        else $error("debug");
    chk_store_route: assert property (movx_dptr_store |=> flash_write.we ^ xram_store)
        else $error("route");
    chk_idle_quiet: assert property (!movx_dptr_store |=> !flash_write.we && !xram_store)
        else $error("idle");
    chk_pwe_clear: assert property (flash_write.we && !sfr.we ##1 movx_dptr_store |=> xram_store)
        else $error("clear");
    chk_secure_hold: assert property (readout_block |=> readout_block)
        else $error("secure");
    cover property (erase_cmd.req && erase_cmd.mass);
    cover property (erase_cmd.req && !erase_cmd.mass);
    cover property (flash_write.we);
endmodule : fepc_ctrl_assertions
bind fepc_ctrl fepc_ctrl_assertions chk (.*);

// File: tb/fepc_flash_model.sv
module fepc_flash_model
(
    // Array side.
    input wire logic clk,
    input wire fepc_pkg::fepc_erase_s erase_cmd,
    output wire logic flash_busy
);
    timeunit 1ns / 1ps;
    logic [2:0] n = 3'h0;
    // Busy a few cycles so that a trigger right after an erase meets a busy array.
    always @(posedge clk) n <= erase_cmd.req ? 3'h7 : n - 3'(n != 3'h0);
    assign flash_busy = n != 3'h0;
endmodule : fepc_flash_model

// File: tb/tb_flash_erase_program_ctrl.sv
module tb_flash_erase_program_ctrl;
    timeunit 1ns / 1ps;
    import fepc_pkg::*;
    logic clk = 0, reset = 1, irq_global_enabled = 0, movx_dptr_store = 0, debug_port_enabled = 1;
    logic flash_busy, xram_store, readout_block;
    logic [15:0] dptr = 16'h1234;
    logic [7:0] acc = 8'h5a, sfr_rdata;
    fepc_sfr_s sfr = '0;
    fepc_erase_s erase_cmd;
    fepc_byte_s flash_write;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    fepc_ctrl dut (.*);
    fepc_flash_model array (.*);
    task automatic chk(input logic [24:0] s, e);
        total_checks++;
        n_mismatch += int'(s !== e);
        if (s !== e)
            $display("unexpected at %0t: %h %h", $time, s, e);
    endtask : chk
    task automatic op(input logic [2:0] k, input logic [7:0] a, d);
        @(posedge clk) {movx_dptr_store, sfr} <= {k, a, d};
        @(posedge clk) {movx_dptr_store, sfr} <= '0;
        #1;
    endtask : op
    task automatic trg(input logic [7:0] d, input logic [1:0] e);
        op(3'h2, 8'h94, d);
        chk(erase_cmd[8:7], e);
    endtask : trg
    task automatic print_verdict;
        n_mismatch += int'(cyc >= 1000);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
        if (++cyc == 1000)
            print_verdict();
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 0;
        // The core clock is taken as already slowed for flash work before any of these calls.
        op(3'h2, 8'hb7, 8'h0b);
        op(3'h1, 8'hb7, 8'h00);
        chk(sfr_rdata, 8'h0b);
        op(3'h2, 8'h94, 8'h55);
        chk(erase_cmd, 9'h105);
        op(3'h2, 8'hb7, 8'h0b);
        trg(8'h55, 2'h0);
        repeat (8) @(posedge clk);
        trg(8'h5a, 2'h0);
        trg(8'haa, 2'h0);
        op(3'h2, 8'hb2, 8'h02);
        trg(8'haa, 2'h3);
        repeat (8) @(posedge clk);
        debug_port_enabled <= 0;
        op(3'h2, 8'hb2, 8'h02);
        repeat (4) @(posedge clk);
        trg(8'haa, 2'h0);
        @(posedge clk) irq_global_enabled <= 1;
        op(3'h2, 8'hb2, 8'h01);
        op(3'h4, 8'h00, 8'h00);
        chk(xram_store, 1'b1);
        @(posedge clk) irq_global_enabled <= 0;
        op(3'h2, 8'hb2, 8'h01);
        op(3'h1, 8'hb2, 8'h00);
        chk(sfr_rdata, 8'h01);
        op(3'h4, 8'h00, 8'h00);
        chk(flash_write, 25'h112345a);
        op(3'h4, 8'h00, 8'h00);
        chk(xram_store, 1'b1);
        op(3'h1, 8'hb2, 8'h00);
        chk(sfr_rdata, 8'h00);
        op(3'h2, 8'hb2, 8'h40);
        op(3'h2, 8'hb2, 8'h00);
        chk(readout_block, 1'b1);
        op(3'h1, 8'hb2, 8'h00);
        chk(sfr_rdata, 8'h40);
        @(posedge clk) reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        op(3'h1, 8'hb2, 8'h00);
        chk(sfr_rdata, 8'h00);
        chk(readout_block, 1'b0);
        print_verdict();
    end
endmodule : tb_flash_erase_program_ctrl
